/* File: pkg/scs_pkg.sv */
// Shared constants and carriers of the serial configuration slave
package scs_pkg;

	// Own 7-bit bus address; the full address byte adds the direction bit
	localparam logic [6:0] SCS_SLV_ADDR = 7'h69;
	localparam logic SCS_DIR_READ = 1'b1;

	// Command code layout
	localparam int SCS_CMD_MODE_BIT = 7;
	localparam int SCS_IDX_W = 7;

	// Bits per byte on the wire, counter value at a completed byte
	localparam logic [3:0] SCS_BYTE_BITS = 4'h8;

	// Configuration bytes and their power-up values, byte 0 in the low bits
	localparam int SCS_NUM_BYTES = 6;
	localparam logic [47:0] SCS_CFG_DEFAULT = 48'h00_00_ef_7f_ff_00;

	// Serial pins seen by the slave
	typedef struct packed {
		logic scl;
		logic sda;
	} scs_pin_in_s;

	// Data line drive: the pin is open drain, so only the enable moves
	typedef struct packed {
		logic sda;
		logic sda_oe;
	} scs_pin_out_s;

	typedef enum logic [3:0] {
		ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_CMD, ST_CMD_ACK, ST_CNT, ST_CNT_ACK,
		ST_WR, ST_WR_ACK, ST_RD, ST_RD_ACK, ST_IGNORE
	} scs_state_e;

endpackage : scs_pkg

/* File: rtl/scs_smbus_slave.sv */
// Serial configuration slave holding the clock-buffer configuration bytes
`timescale 1ns/1ns

// Overview of operation
// - Answer only address bytes 11010010 and 11010011, seven address bits plus direction.
// - Support byte write, byte read, block write and block read.
// - Block bytes go in ascending order, each most significant bit first.
// - A stop after any complete byte ends a block; finished bytes stay.
// - Command bit 7 low means block transfer, high means single byte.
// - Command bits 6..0 index single bytes; block commands carry zeros.
// - Block write: address, command, count, data, each acknowledged, then stop.
// - Block read: command written, repeated start, read address, count returned.
// - Block read data follows the count; host leaves the last unacknowledged.
// - Byte write: address, command with bit 7 and offset, one data byte.
// - Byte read: command written, repeated start, one byte, host not acknowledging.
// - All configuration bytes load their defaults at reset.
// - Written bytes enable or disable each output buffer independently.
// - Updates are accepted at any time during operation.
module scs_smbus_slave
	import scs_pkg::*;
#(
	parameter int NUM_BYTES = scs_pkg::SCS_NUM_BYTES,
	parameter logic [NUM_BYTES*8-1:0] CFG_DEFAULT = scs_pkg::SCS_CFG_DEFAULT
) (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic nrst_i,
	// Serial bus pins
	input wire scs_pkg::scs_pin_in_s pin_i,
	output scs_pkg::scs_pin_out_s pin_o,
	// Configuration bytes, byte 0 in the low bits
	output logic [NUM_BYTES*8-1:0] cfg_o
);
	import scs_pkg::*;

	logic scl_q;
	logic sda_q;
	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;
	logic byte_done;
	logic wr_en;
	scs_state_e state_q;
	logic [3:0] bit_cnt_q;
	logic [7:0] shift_q;
	logic [7:0] tx_q;
	logic [7:0] tx_next;
	logic rw_q;
	logic block_q;
	logic cnt_sent_q;
	logic host_ack_q;
	logic [SCS_IDX_W-1:0] idx_q;
	logic sda_oe_q;
	logic [NUM_BYTES-1:0][7:0] cfg_q;

	assign scl_rise = pin_i.scl & ~scl_q;
	assign scl_fall = ~pin_i.scl & scl_q;
	assign start_det = pin_i.scl & scl_q & sda_q & ~pin_i.sda;
	assign stop_det = pin_i.scl & scl_q & ~sda_q & pin_i.sda;
	assign byte_done = (bit_cnt_q == SCS_BYTE_BITS);

	// Block read returns the byte count first, then the indexed bytes
	always_comb begin
		tx_next = 8'h00;
		if (block_q && !cnt_sent_q) begin
			tx_next = 8'(NUM_BYTES);
		end else if (int'(idx_q) < NUM_BYTES) begin
			tx_next = cfg_q[idx_q];
		end
	end

	assign wr_en = scl_fall & (state_q == ST_WR) & byte_done & ~start_det & ~stop_det;

	// Line sampling for edge and condition detection
	always_ff @(posedge core_clk_i) begin
		if (!nrst_i) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= pin_i.scl;
			sda_q <= pin_i.sda;
		end
	end

	// Receive shifter and bit counter
	always_ff @(posedge core_clk_i) begin
		if (!nrst_i) begin
			shift_q <= 8'h00;
			bit_cnt_q <= 4'h0;
			host_ack_q <= 1'b0;
		end else if (start_det || stop_det) begin
			bit_cnt_q <= 4'h0;
		end else if (scl_rise) begin
			shift_q <= {shift_q[6:0], pin_i.sda};
			if (state_q == ST_RD_ACK) begin
				host_ack_q <= ~pin_i.sda;
			end else if (bit_cnt_q != SCS_BYTE_BITS) begin
				bit_cnt_q <= bit_cnt_q + 4'h1;
			end
		end else if (scl_fall && (byte_done || state_q inside {ST_ADDR_ACK, ST_CMD_ACK,
				ST_CNT_ACK, ST_WR_ACK, ST_RD_ACK})) begin
			// Every acknowledge slot hands the next byte a fresh count
			bit_cnt_q <= 4'h0;
		end
	end

	// Transfer sequencer
	always_ff @(posedge core_clk_i) begin
		if (!nrst_i) begin
			state_q <= ST_IDLE;
			sda_oe_q <= 1'b0;
			rw_q <= 1'b0;
			block_q <= 1'b0;
			cnt_sent_q <= 1'b0;
			idx_q <= '0;
			tx_q <= 8'h00;
		end else if (stop_det) begin
			state_q <= ST_IDLE;
			sda_oe_q <= 1'b0;
		end else if (start_det) begin
			state_q <= ST_ADDR;
			sda_oe_q <= 1'b0;
			cnt_sent_q <= 1'b0;
		end else if (scl_fall) begin
			case (state_q)
				ST_ADDR: begin
					if (byte_done) begin
						if (shift_q[7:1] == SCS_SLV_ADDR) begin
							rw_q <= shift_q[0];
							sda_oe_q <= 1'b1;
							state_q <= ST_ADDR_ACK;
						end else begin
							state_q <= ST_IGNORE;
						end
					end
				end
				ST_ADDR_ACK: begin
					if (rw_q == SCS_DIR_READ) begin
						tx_q <= tx_next;
						sda_oe_q <= ~tx_next[7];
						state_q <= ST_RD;
						if (block_q && !cnt_sent_q) begin
							cnt_sent_q <= 1'b1;
						end else if (block_q) begin
							idx_q <= idx_q + 1'b1;
						end
					end else begin
						sda_oe_q <= 1'b0;
						state_q <= ST_CMD;
					end
				end
				ST_CMD: begin
					if (byte_done) begin
						block_q <= ~shift_q[SCS_CMD_MODE_BIT];
						idx_q <= shift_q[SCS_CMD_MODE_BIT] ? shift_q[6:0] : '0;
						sda_oe_q <= 1'b1;
						state_q <= ST_CMD_ACK;
					end
				end
				ST_CMD_ACK: begin
					sda_oe_q <= 1'b0;
					state_q <= block_q ? ST_CNT : ST_WR;
				end
				ST_CNT: begin
					if (byte_done) begin
						sda_oe_q <= 1'b1;
						state_q <= ST_CNT_ACK;
					end
				end
				ST_CNT_ACK: begin
					sda_oe_q <= 1'b0;
					state_q <= ST_WR;
				end
				ST_WR: begin
					if (byte_done) begin
						if (block_q) begin
							idx_q <= idx_q + 1'b1;
						end
						sda_oe_q <= 1'b1;
						state_q <= ST_WR_ACK;
					end
				end
				ST_WR_ACK: begin
					sda_oe_q <= 1'b0;
					state_q <= ST_WR;
				end
				ST_RD: begin
					if (byte_done) begin
						sda_oe_q <= 1'b0;
						state_q <= ST_RD_ACK;
					end else begin
						tx_q <= {tx_q[6:0], 1'b0};
						sda_oe_q <= ~tx_q[6];
					end
				end
				ST_RD_ACK: begin
					if (host_ack_q) begin
						tx_q <= tx_next;
						sda_oe_q <= ~tx_next[7];
						state_q <= ST_RD;
						if (block_q && !cnt_sent_q) begin
							cnt_sent_q <= 1'b1;
						end else if (block_q) begin
							idx_q <= idx_q + 1'b1;
						end
					end else begin
						state_q <= ST_IGNORE;
					end
				end
				default: begin
					sda_oe_q <= 1'b0;
				end
			endcase
		end
	end

	// both write transfer kinds, byte write and block write
	// Configuration storage, written in place at any time
	always_ff @(posedge core_clk_i) begin
		if (!nrst_i) begin
			cfg_q <= CFG_DEFAULT;
		end else if (wr_en && int'(idx_q) < NUM_BYTES) begin
			cfg_q[idx_q] <= shift_q;
		end
	end

	assign cfg_o = cfg_q;
	assign pin_o = {1'b0, sda_oe_q};

	a_addr_foreign: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
		scl_fall && !start_det && !stop_det && state_q == ST_ADDR && byte_done
		&& shift_q[7:1] != SCS_SLV_ADDR |=> state_q == ST_IGNORE && !sda_oe_q)
		else $error("foreign address was answered");

	a_ignore_quiet: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
		state_q == ST_IGNORE |-> !sda_oe_q)
		else $error("data line driven while ignoring");

	a_cmd_mode: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
		scl_fall && !start_det && !stop_det && state_q == ST_CMD && byte_done
		|=> block_q == !$past(shift_q[7]) && state_q == ST_CMD_ACK && sda_oe_q)
		else $error("command mode decoded wrongly");

	a_cmd_offset: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
		scl_fall && !start_det && !stop_det && state_q == ST_CMD && byte_done
		&& shift_q[7] |=> idx_q == $past(shift_q[6:0]))
		else $error("byte offset not taken from command");

	a_block_zero: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
		scl_fall && !start_det && !stop_det && state_q == ST_CMD && byte_done
		&& !shift_q[7] |=> idx_q == '0)
		else $error("block did not start at byte zero");

	a_write_store: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
		wr_en && int'(idx_q) < NUM_BYTES |=> cfg_q[$past(idx_q)] == $past(shift_q))
		else $error("received byte not stored");

	a_index_step: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
		wr_en && block_q |=> idx_q == $past(idx_q) + 1'b1)
		else $error("block index did not step by one");

	a_reset_default: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
		$rose(nrst_i) |-> cfg_q == CFG_DEFAULT)
		else $error("configuration not at defaults after reset");

	a_stop_release: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
		stop_det |=> state_q == ST_IDLE && !sda_oe_q)
		else $error("stop did not end the transfer");

	a_read_msb: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
		scl_fall && !start_det && !stop_det && state_q == ST_RD && !byte_done
		|=> sda_oe_q == !$past(tx_q[6]))
		else $error("read bit order wrong");

	c_block_write: cover property (@(posedge core_clk_i) disable iff (!nrst_i)
		wr_en && block_q);
	c_byte_read: cover property (@(posedge core_clk_i) disable iff (!nrst_i)
		state_q == ST_RD && !block_q);
	c_block_read_data: cover property (@(posedge core_clk_i) disable iff (!nrst_i)
		state_q == ST_RD && block_q && cnt_sent_q && idx_q > 1);

endmodule : scs_smbus_slave

/* File: bench/scs_host.sv */
// Bus controller model driving the serial pins of the slave
`timescale 1ns/1ns
module scs_host (
	// Clock and resolved data line
	input wire logic core_clk_i,
	input wire logic sda_wire_i,
	// Driven lines, released high through the pull-ups
	output logic scl_o,
	output logic sda_o
);
	logic [7:0] rsp;
	event rsp_ev;
	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end
	task automatic tk(input int n);
		repeat (n) @(posedge core_clk_i);
		#2;
	endtask : tk
	// Data changes only while the clock line is low
	task automatic bitx(input logic b, output logic r);
		tk(2);
		sda_o = b;
		tk(3);
		scl_o = 1'b1;
		tk(3);
		r = sda_wire_i;
		tk(1);
		scl_o = 1'b0;
	endtask : bitx
	task automatic start();
		tk(2);
		sda_o = 1'b1;
		tk(2);
		scl_o = 1'b1;
		tk(4);
		sda_o = 1'b0;
		tk(4);
		scl_o = 1'b0;
	endtask : start
	task automatic stop();
		tk(2);
		sda_o = 1'b0;
		tk(2);
		scl_o = 1'b1;
		tk(4);
		sda_o = 1'b1;
		tk(4);
	endtask : stop
	task automatic wr_byte(input logic [7:0] d);
		logic a;
		for (int i = 7; i >= 0; i--) bitx(d[i], a);
		bitx(1'b1, a);
		rsp = {7'h00, a};
		->rsp_ev;
	endtask : wr_byte
	task automatic rd_byte(input logic nack);
		logic [7:0] d;
		logic a;
		for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
		bitx(nack, a);
		rsp = d;
		->rsp_ev;
	endtask : rd_byte
endmodule : scs_host

/* File: bench/testbench.sv */
// Self-checking bench for the serial configuration slave
`timescale 1ns/1ns
module testbench;
	import scs_pkg::*;
	logic core_clk_i;
	logic nrst_i;
	scs_pin_in_s pin_i;
	scs_pin_out_s pin_o;
	logic [47:0] cfg_o;
	logic scl_h;
	logic sda_h;
	logic quiet;
	logic [47:0] exp_cfg;
	logic [7:0] exp_q[$];
	logic [31:0] seed;
	int n_fail;
	int num_checks;
	assign pin_i = {scl_h, sda_h & (pin_o.sda_oe ? pin_o.sda : 1'b1)};
	scs_smbus_slave dut_u (.core_clk_i, .nrst_i, .pin_i, .pin_o, .cfg_o);
	scs_host host_u (.core_clk_i(core_clk_i), .sda_wire_i(pin_i.sda), .scl_o(scl_h),
		.sda_o(sda_h));
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	task automatic chk(input logic [47:0] seen, input logic [47:0] exp, input string what);
		num_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic conclude();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : conclude
	task automatic tx(input logic [7:0] d, input logic a);
		exp_q.push_back({7'h00, a});
		host_u.wr_byte(d);
	endtask : tx
	task automatic rx(input logic [7:0] e, input logic nack);
		exp_q.push_back(e);
		host_u.rd_byte(nack);
	endtask : rx
	always @(host_u.rsp_ev) begin
		if (exp_q.size() == 0) begin
			chk(48'h1, 48'h0, "unexpected bus byte");
		end else begin
			chk({40'h0, host_u.rsp}, {40'h0, exp_q.pop_front()}, "bus byte");
		end
	end
	always @(posedge core_clk_i) begin
		if (quiet) begin
			chk({47'h0, pin_o.sda_oe}, 48'h0, "foreign drive");
		end
	end
	initial begin
		core_clk_i = 1'b0;
		forever #10 core_clk_i = ~core_clk_i;
	end
	initial begin
		repeat (100000) @(posedge core_clk_i);
		chk(48'h1, 48'h0, "timeout");
		conclude();
	end
	initial begin
		logic [7:0] v;
		nrst_i = 1'b0;
		quiet = 1'b0;
		seed = 32'd82977;
		exp_cfg = SCS_CFG_DEFAULT;
		repeat (4) @(posedge core_clk_i);
		#2 nrst_i = 1'b1;
		chk(cfg_o, SCS_CFG_DEFAULT, "reset defaults");
		for (int i = 0; i < SCS_NUM_BYTES; i++) begin
			seed = lfsr(seed);
			v = seed[7:0];
			exp_cfg[i*8 +: 8] = v;
			host_u.start();
			tx(8'hd2, 1'b0);
			tx({1'b1, i[6:0]}, 1'b0);
			tx(v, 1'b0);
			host_u.stop();
			chk(cfg_o, exp_cfg, "byte write");
			host_u.start();
			tx(8'hd2, 1'b0);
			tx({1'b1, i[6:0]}, 1'b0);
			host_u.start();
			tx(8'hd3, 1'b0);
			rx(v, 1'b1);
			host_u.stop();
		end
		$display("done: byte write and read");
		host_u.start();
		tx(8'hd2, 1'b0);
		tx(8'h00, 1'b0);
		tx(8'h03, 1'b0);
		for (int i = 0; i < 3; i++) begin
			seed = lfsr(seed);
			exp_cfg[i*8 +: 8] = seed[7:0];
			tx(seed[7:0], 1'b0);
		end
		host_u.stop();
		chk(cfg_o, exp_cfg, "block write");
		$display("done: block write");
		host_u.start();
		tx(8'hd2, 1'b0);
		tx(8'h00, 1'b0);
		host_u.start();
		tx(8'hd3, 1'b0);
		rx(8'(SCS_NUM_BYTES), 1'b0);
		for (int i = 0; i < SCS_NUM_BYTES; i++) begin
			rx(exp_cfg[i*8 +: 8], i == SCS_NUM_BYTES - 1);
		end
		host_u.stop();
		$display("done: block read");
		quiet = 1'b1;
		host_u.start();
		tx(8'hd0, 1'b1);
		tx(8'h81, 1'b1);
		tx(8'h00, 1'b1);
		host_u.stop();
		quiet = 1'b0;
		chk(cfg_o, exp_cfg, "foreign write");
		$display("done: foreign address");
		nrst_i = 1'b0;
		repeat (2) @(posedge core_clk_i);
		#2 nrst_i = 1'b1;
		chk(cfg_o, SCS_CFG_DEFAULT, "second reset");
		$display("done: second reset");
		chk(48'(exp_q.size()), 48'h0, "pending bytes");
		conclude();
	end
endmodule : testbench
